// ---- rtl/csx_pkg.sv ----
// package: command codes, status codes, limits, states and state record of the coordinate block
package csx_pkg;
   // ****************************************
   // command and status codes
   // ****************************************
   localparam logic [7:0] CMD_COORD_READ    = 8'h1F;
   localparam logic [7:0] CMD_POS_CAPTURE   = 8'h20;
   localparam logic [7:0] CMD_XCALC         = 8'h21;
   localparam logic [7:0] CMD_ACCU_TO_COORD = 8'h27;
   localparam logic [7:0] ST_OK             = 8'h64;
   localparam logic [7:0] ST_BAD_CSUM       = 8'h01;
   localparam logic [7:0] ST_BAD_CMD        = 8'h02;
   localparam logic [7:0] ST_BAD_VALUE      = 8'h04;
   // ****************************************
   // limits and field positions
   // ****************************************
   localparam logic [7:0] MOTOR_NV_SEL      = 8'hFF;
   localparam logic [7:0] MAX_COORD         = 8'h14;
   localparam logic [7:0] MAX_AXIS          = 8'h05;
   localparam logic [7:0] MAX_XOP           = 8'h0A;
   localparam logic [7:0] NV_SETTING_NUM    = 8'h54;
   localparam logic [3:0] FRAME_LAST        = 4'h8;
   localparam logic [3:0] POS_ADDR          = 4'h0;
   localparam logic [3:0] POS_CMD           = 4'h1;
   localparam logic [3:0] POS_TYPE          = 4'h2;
   localparam logic [3:0] POS_MOTOR         = 4'h3;
   localparam logic [6:0] COORDS_PER_AXIS   = 7'h15;
   localparam int         NUM_AXES          = 6;
   localparam int         MEM_DEPTH         = 126;
   localparam logic [7:0] MODULE_ADDR_RST   = 8'h01;
   localparam logic [31:0] ACCU_RST         = 32'h0000_0000;
   localparam logic [31:0] XREG_RST         = 32'h0000_0000;
   // ****************************************
   // calculation selectors
   // ****************************************
   localparam logic [3:0] XOP_ADD  = 4'h0;
   localparam logic [3:0] XOP_SUB  = 4'h1;
   localparam logic [3:0] XOP_MUL  = 4'h2;
   localparam logic [3:0] XOP_DIV  = 4'h3;
   localparam logic [3:0] XOP_MOD  = 4'h4;
   localparam logic [3:0] XOP_AND  = 4'h5;
   localparam logic [3:0] XOP_OR   = 4'h6;
   localparam logic [3:0] XOP_XOR  = 4'h7;
   localparam logic [3:0] XOP_NOT  = 4'h8;
   localparam logic [3:0] XOP_LOAD = 4'h9;
   localparam logic [3:0] XOP_SWAP = 4'hA;
   // ****************************************
   // states and state record
   // ****************************************
   typedef enum logic [4:0] {
      S_BOOT  = 5'b00001,
      S_IDLE  = 5'b00010,
      S_EXEC  = 5'b00100,
      S_NV_RD = 5'b01000,
      S_NV_WR = 5'b10000
   } csx_state_e_t;

   typedef struct packed {
      csx_state_e_t st;
      logic [3:0]   cnt;
      logic [7:0]   sum;
      logic [7:0]   addr;
      logic [7:0]   cmd;
      logic [7:0]   typ;
      logic [7:0]   mot;
      logic [31:0]  val;
      logic         direct;
      logic         all;
      logic [31:0]  accu;
      logic [31:0]  xreg;
      logic         rx_ready;
      logic         rep_valid;
      logic [7:0]   rep_status;
      logic [31:0]  rep_value;
      logic         nv_rd;
      logic         nv_wr;
      logic [2:0]   nv_axis;
      logic [4:0]   nv_index;
      logic [31:0]  nv_wdata;
   } csx_regs_t;
endpackage

// ---- rtl/csx_alu_if.sv ----
// interface: operands and results between the command logic and the x register calculator
`timescale 1ns/1ps
`default_nettype none
interface csx_alu_if;
   logic [31:0] accu;
   logic [31:0] xreg;
   logic [3:0]  op;
   logic [31:0] accu_res;
   logic [31:0] xreg_res;
   modport ctrl (output accu, output xreg, output op, input accu_res, input xreg_res);
   modport alu  (input accu, input xreg, input op, output accu_res, output xreg_res);
endinterface
`default_nettype wire

// ---- rtl/csx_alu.sv ----
// module: x register calculator, combinational
`timescale 1ns/1ps
`default_nettype none
module csx_alu
   import csx_pkg::*;
(
   csx_alu_if.alu bus
);
   logic signed [31:0] sa;
   logic signed [31:0] sx;
   logic        [31:0] ar;
   logic        [31:0] xr;

   // ****************************************
   // operation select
   // ****************************************
   always_comb begin
      sa = $signed(bus.accu);
      sx = $signed(bus.xreg);
      ar = bus.accu;
      xr = bus.xreg;
      case (bus.op)
         XOP_ADD: ar = bus.accu + bus.xreg;
         XOP_SUB: ar = bus.accu - bus.xreg;
         XOP_MUL: ar = bus.accu * bus.xreg;
         XOP_DIV: begin
            if (bus.xreg != 32'h0000_0000) ar = 32'(sa / sx);
         end
         XOP_MOD: begin
            if (bus.xreg != 32'h0000_0000) ar = 32'(sa % sx);
         end
         XOP_AND: ar = bus.accu & bus.xreg;
         XOP_OR:  ar = bus.accu | bus.xreg;
         XOP_XOR: ar = bus.accu ^ bus.xreg;
         XOP_NOT: xr = ~bus.xreg;
         XOP_LOAD: xr = bus.accu;
         XOP_SWAP: begin
            ar = bus.xreg;
            xr = bus.accu;
         end
         default: ar = bus.accu;
      endcase
   end

   assign bus.accu_res = ar;
   assign bus.xreg_res = xr;
endmodule
`default_nettype wire

// ---- rtl/csx_top.sv ----
// module: coordinate store and x register calculation command logic
`timescale 1ns/1ps
`default_nettype none
module csx_top
   import csx_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   input  wire logic                   byte_valid,
   input  wire logic [7:0]             byte_data,
   input  wire logic                   direct_mode,
   input  wire logic                   nv_keep,
   input  wire logic [NUM_AXES*32-1:0] act_pos,
   input  wire logic                   nv_ack,
   input  wire logic [31:0]            nv_rdata,
   output logic                        rx_ready,
   output logic                        rep_valid,
   output logic [7:0]                  rep_status,
   output logic [31:0]                 rep_value,
   output logic [31:0]                 accu_out,
   output logic [31:0]                 xreg_out,
   output logic                        nv_rd_req,
   output logic                        nv_wr_req,
   output logic [2:0]                  nv_axis,
   output logic [4:0]                  nv_index,
   output logic [31:0]                 nv_wdata
);
   csx_regs_t   r_reg;
   csx_regs_t   r_next;
   logic [31:0] coord_mem [MEM_DEPTH];
   logic        mem_we;
   logic [6:0]  mem_addr;
   logic [31:0] mem_wdata;
   logic [31:0] rd_data;
   logic [31:0] sel_pos;
   logic        sel_ok;
   logic        csum_bad;
   csx_alu_if   alu_bus ();

   function automatic logic [6:0] caddr(logic [2:0] ax, logic [4:0] ix);
      logic [6:0] base;
      base  = 7'(7'(ax) * COORDS_PER_AXIS);
      caddr = base + {2'b00, ix};
   endfunction

   csx_alu u_alu (
      .bus (alu_bus.alu)
   );

   assign alu_bus.accu = r_reg.accu;
   assign alu_bus.xreg = r_reg.xreg;
   assign alu_bus.op   = r_reg.typ[3:0];
   assign sel_ok       = (r_reg.typ <= MAX_COORD) && (r_reg.mot <= MAX_AXIS);
   assign rd_data      = coord_mem[caddr(r_reg.mot[2:0], r_reg.typ[4:0])];
   assign sel_pos      = act_pos[32*r_reg.mot[2:0] +: 32];
   assign csum_bad     = r_reg.direct && (byte_data != r_reg.sum);

   // ****************************************
   // command sequencing
   // ****************************************
   always_comb begin
      r_next           = r_reg;
      r_next.rep_valid = 1'b0;
      mem_we           = 1'b0;
      mem_addr         = caddr(r_reg.mot[2:0], r_reg.typ[4:0]);
      mem_wdata        = r_reg.accu;
      case (r_reg.st)
         S_BOOT: begin
            // startup reload only when stored copy kept
            if (nv_keep) begin
               r_next.st       = S_NV_RD;
               r_next.direct   = 1'b0;
               r_next.all      = 1'b1;
               r_next.nv_rd    = 1'b1;
               r_next.nv_axis  = 3'h0;
               r_next.nv_index = 5'h01;
            end else begin
               r_next.st       = S_IDLE;
               r_next.rx_ready = 1'b1;
            end
         end
         S_IDLE: begin
            if (byte_valid) begin
               case (r_reg.cnt)
                  POS_ADDR:  r_next.addr = byte_data;
                  POS_CMD:   r_next.cmd  = byte_data;
                  POS_TYPE:  r_next.typ  = byte_data;
                  POS_MOTOR: r_next.mot  = byte_data;
                  default:   r_next.val  = {r_reg.val[23:0], byte_data};
               endcase
               if (r_reg.cnt == POS_ADDR) begin
                  r_next.direct = direct_mode;
               end
               if (r_reg.cnt != FRAME_LAST) begin
                  r_next.cnt = r_reg.cnt + 4'h1;
                  r_next.sum = r_reg.sum + byte_data;
               end else begin
                  r_next.cnt = 4'h0;
                  r_next.sum = 8'h00;
                  if (csum_bad) begin
                     r_next.rep_valid  = 1'b1;
                     r_next.rep_status = ST_BAD_CSUM;
                     r_next.rep_value  = 32'h0000_0000;
                  end else if (!r_reg.direct || r_reg.addr == MODULE_ADDR_RST) begin
                     r_next.st       = S_EXEC;
                     r_next.rx_ready = 1'b0;
                  end
               end
            end
         end
         S_EXEC: begin
            r_next.st         = S_IDLE;
            r_next.rx_ready   = 1'b1;
            r_next.rep_valid  = r_reg.direct;
            r_next.rep_status = ST_OK;
            r_next.rep_value  = 32'h0000_0000;
            case (r_reg.cmd)
               CMD_COORD_READ: begin
                  if (r_reg.mot == MOTOR_NV_SEL && r_reg.typ <= MAX_COORD) begin
                     r_next.st        = S_NV_RD;
                     r_next.rx_ready  = 1'b0;
                     r_next.rep_valid = 1'b0;
                     r_next.all       = (r_reg.typ == 8'h00);
                     r_next.nv_rd     = 1'b1;
                     r_next.nv_axis   = 3'h0;
                     r_next.nv_index  = (r_reg.typ == 8'h00) ? 5'h01 : r_reg.typ[4:0];
                  end else if (!sel_ok) begin
                     r_next.rep_status = ST_BAD_VALUE;
                  end else if (r_reg.direct) begin
                     r_next.rep_value = rd_data;
                  end else begin
                     r_next.accu = rd_data;
                  end
               end
               CMD_POS_CAPTURE, CMD_ACCU_TO_COORD: begin
                  if (!sel_ok) begin
                     r_next.rep_status = ST_BAD_VALUE;
                  end else begin
                     mem_we = 1'b1;
                     mem_wdata = (r_reg.cmd == CMD_POS_CAPTURE) ? sel_pos : r_reg.accu;
                     if (nv_keep && r_reg.typ != 8'h00) begin
                        r_next.st        = S_NV_WR;
                        r_next.rx_ready  = 1'b0;
                        r_next.rep_valid = 1'b0;
                        r_next.nv_wr     = 1'b1;
                        r_next.nv_axis   = r_reg.mot[2:0];
                        r_next.nv_index  = r_reg.typ[4:0];
                        r_next.nv_wdata  = mem_wdata;
                     end
                  end
               end
               CMD_XCALC: begin
                  if (r_reg.typ <= MAX_XOP) begin
                     r_next.accu = alu_bus.accu_res;
                     r_next.xreg = alu_bus.xreg_res;
                  end else begin
                     r_next.rep_status = ST_BAD_VALUE;
                  end
               end
               default: r_next.rep_status = ST_BAD_CMD;
            endcase
         end
         S_NV_RD: begin
            mem_addr  = caddr(r_reg.nv_axis, r_reg.nv_index);
            mem_wdata = nv_rdata;
            if (nv_ack) begin
               mem_we = 1'b1;
               if (r_reg.nv_axis != MAX_AXIS[2:0]) begin
                  r_next.nv_axis = r_reg.nv_axis + 3'h1;
               end else if (r_reg.all && r_reg.nv_index != MAX_COORD[4:0]) begin
                  r_next.nv_axis  = 3'h0;
                  r_next.nv_index = r_reg.nv_index + 5'h01;
               end else begin
                  r_next.nv_rd      = 1'b0;
                  r_next.st         = S_IDLE;
                  r_next.rx_ready   = 1'b1;
                  r_next.rep_valid  = r_reg.direct;
                  r_next.rep_status = ST_OK;
                  r_next.rep_value  = 32'h0000_0000;
               end
            end
         end
         S_NV_WR: begin
            if (nv_ack) begin
               r_next.nv_wr      = 1'b0;
               r_next.st         = S_IDLE;
               r_next.rx_ready   = 1'b1;
               r_next.rep_valid  = r_reg.direct;
               r_next.rep_status = ST_OK;
               r_next.rep_value  = 32'h0000_0000;
            end
         end
         default: r_next.st = S_IDLE;
      endcase
   end

   // ****************************************
   // registers and coordinate storage
   // ****************************************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         r_reg          <= '0;
         r_reg.st       <= S_BOOT;
         r_reg.accu     <= ACCU_RST;
         r_reg.xreg     <= XREG_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         coord_mem[mem_addr] <= mem_wdata;
      end
   end

   assign rx_ready   = r_reg.rx_ready;
   assign rep_valid  = r_reg.rep_valid;
   assign rep_status = r_reg.rep_status;
   assign rep_value  = r_reg.rep_value;
   assign accu_out   = r_reg.accu;
   assign xreg_out   = r_reg.xreg;
   assign nv_rd_req  = r_reg.nv_rd;
   assign nv_wr_req  = r_reg.nv_wr;
   assign nv_axis    = r_reg.nv_axis;
   assign nv_index   = r_reg.nv_index;
   assign nv_wdata   = r_reg.nv_wdata;

   // ****************************************
   // checks
   // ****************************************
   property p_host_read;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_EXEC && r_reg.cmd == CMD_COORD_READ && sel_ok && r_reg.direct)
      |=> rep_valid && rep_status == ST_OK && rep_value == $past(rd_data) && $stable(accu_out);
   endproperty
   a_host_read: assert property (p_host_read) else $error("host read reply wrong");

   property p_prog_read;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_EXEC && r_reg.cmd == CMD_COORD_READ && sel_ok && !r_reg.direct)
      |=> accu_out == $past(rd_data) && !rep_valid;
   endproperty
   a_prog_read: assert property (p_prog_read) else $error("program read missed accu");

   property p_capture;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_EXEC && r_reg.cmd == CMD_POS_CAPTURE && sel_ok)
      |-> mem_we && mem_wdata == sel_pos && mem_addr == caddr(r_reg.mot[2:0], r_reg.typ[4:0]);
   endproperty
   a_capture: assert property (p_capture) else $error("capture write wrong");

   property p_accu_store;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_EXEC && r_reg.cmd == CMD_ACCU_TO_COORD && sel_ok)
      |-> mem_we && mem_wdata == accu_out;
   endproperty
   a_accu_store: assert property (p_accu_store) else $error("accu store wrong");

   property p_xcalc;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_EXEC && r_reg.cmd == CMD_XCALC && r_reg.typ <= MAX_XOP)
      |=> accu_out == $past(alu_bus.accu_res) && xreg_out == $past(alu_bus.xreg_res);
   endproperty
   a_xcalc: assert property (p_xcalc) else $error("x calc result lost");

   property p_csum;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_IDLE && byte_valid && r_reg.cnt == FRAME_LAST && r_reg.direct
       && byte_data != r_reg.sum)
      |=> rep_valid && rep_status == ST_BAD_CSUM && r_reg.st == S_IDLE;
   endproperty
   a_csum: assert property (p_csum) else $error("bad checksum accepted");

   property p_no_zero_nv;
      @(posedge ref_clk) disable iff (!reset_n)
      (nv_rd_req || nv_wr_req) |-> nv_index != 5'h00 && nv_index <= MAX_COORD[4:0];
   endproperty
   a_no_zero_nv: assert property (p_no_zero_nv) else $error("index zero in storage");

   property p_ram_only;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_EXEC && !nv_keep) |=> !nv_wr_req;
   endproperty
   a_ram_only: assert property (p_ram_only) else $error("stored copy while ram only");

   property p_reload_all;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_EXEC && r_reg.cmd == CMD_COORD_READ && r_reg.mot == MOTOR_NV_SEL
       && r_reg.typ == 8'h00)
      |=> nv_rd_req && nv_index == 5'h01 && nv_axis == 3'h0 && !rep_valid;
   endproperty
   a_reload_all: assert property (p_reload_all) else $error("reload all not started");

   property p_reload_one;
      @(posedge ref_clk) disable iff (!reset_n)
      (r_reg.st == S_EXEC && r_reg.cmd == CMD_COORD_READ && r_reg.mot == MOTOR_NV_SEL
       && r_reg.typ != 8'h00 && r_reg.typ <= MAX_COORD)
      |=> nv_rd_req && nv_index == $past(r_reg.typ[4:0]);
   endproperty
   a_reload_one: assert property (p_reload_one) else $error("single reload index wrong");
endmodule
`default_nettype wire

// ---- dv/csx_nv_model.sv ----
// storage model: nonvolatile copy of the coordinates, answering read and write requests
`timescale 1ns/1ps
`default_nettype none
module csx_nv_model (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        nv_rd_req,
   input  wire logic        nv_wr_req,
   input  wire logic [2:0]  nv_axis,
   input  wire logic [4:0]  nv_index,
   input  wire logic [31:0] nv_wdata,
   output var  logic        nv_ack,
   output var  logic [31:0] nv_rdata,
   output var  int          rd_count,
   output var  int          wr_count,
   output var  int          zero_hits
);
   logic [31:0] mem [0:5][0:20];
   logic [1:0]  wait_cnt;
   logic        slow;
   initial begin
      for (int a = 0; a < 6; a++) begin
         for (int i = 0; i < 21; i++) begin
            mem[a][i] = {16'hC0DE, 8'(a), 8'(i)};
         end
      end
   end
   // ****************************************
   // request handling, prompt and slow in turn
   // ****************************************
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         nv_ack <= 1'b0;
         wait_cnt <= 2'h0;
         slow <= 1'b0;
         nv_rdata <= 32'hFFFF_FFFF;
         rd_count <= 0;
         wr_count <= 0;
         zero_hits <= 0;
      end else if (nv_ack) begin
         nv_ack <= 1'b0;
         nv_rdata <= ~nv_rdata;
      end else if (nv_rd_req || nv_wr_req) begin
         if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
         end else begin
            nv_ack <= 1'b1;
            wait_cnt <= slow ? 2'h3 : 2'h0;
            slow <= ~slow;
            if (nv_index == 5'h0) begin
               zero_hits <= zero_hits + 1;
            end
            if (nv_rd_req) begin
               nv_rdata <= mem[nv_axis][nv_index];
               rd_count <= rd_count + 1;
            end else begin
               mem[nv_axis][nv_index] <= nv_wdata;
               wr_count <= wr_count + 1;
            end
         end
      end else begin
         nv_rdata <= ~nv_rdata;
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// testbench: coordinate store and x register calculation commands
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import csx_pkg::*;
;
   logic                   ref_clk = 1'b0;
   logic                   reset_n = 1'b0;
   logic                   byte_valid = 1'b0;
   logic [7:0]             byte_data = 8'h00;
   logic                   direct_mode = 1'b0;
   logic                   nv_keep = 1'b0;
   logic [NUM_AXES*32-1:0] act_pos = '0;
   logic                   nv_ack, rx_ready, rep_valid, nv_rd_req, nv_wr_req;
   logic [7:0]             rep_status;
   logic [31:0]            nv_rdata, rep_value, accu_out, xreg_out, nv_wdata;
   logic [2:0]             nv_axis;
   logic [4:0]             nv_index;
   int                     fail_count = 0, checked = 0, rd_count, wr_count, zero_hits;
   always #5 ref_clk = ~ref_clk;
   csx_top csx_top_inst (.ref_clk, .reset_n, .byte_valid, .byte_data, .direct_mode, .nv_keep,
      .act_pos, .nv_ack, .nv_rdata, .rx_ready, .rep_valid, .rep_status, .rep_value, .accu_out,
      .xreg_out, .nv_rd_req, .nv_wr_req, .nv_axis, .nv_index, .nv_wdata);
   csx_nv_model csx_nv_model_inst (.ref_clk, .reset_n, .nv_rd_req, .nv_wr_req, .nv_axis,
      .nv_index, .nv_wdata, .nv_ack, .nv_rdata, .rd_count, .wr_count, .zero_hits);
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic final_report;
      $display("checks=%0d errors=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic hang;
      chk(32'h0, 32'h1);
      final_report;
   endtask
   task automatic wait_ready;
      for (int n = 0; n < 1000 && rx_ready !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
      end
      if (rx_ready !== 1'b1) hang;
   endtask
   task automatic send(input logic [7:0] c, t, m, input logic [31:0] v, input logic d,
                       input logic [7:0] err);
      logic [7:0] f [0:8];
      f = '{8'h01, c, t, m, v[31:24], v[23:16], v[15:8], v[7:0], err};
      for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
      wait_ready;
      for (int i = 0; i < 9; i++) begin
         @(posedge ref_clk);
         direct_mode <= d;
         byte_data <= f[i];
         byte_valid <= 1'b1;
      end
      @(posedge ref_clk);
      byte_valid <= 1'b0;
      #1;
      if (d) begin
         for (int n = 0; n < 1000 && rep_valid !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
         end
         if (rep_valid !== 1'b1) hang;
      end else begin
         wait_ready;
      end
   endtask
   task automatic st(input logic [7:0] s);
      chk({24'h0, rep_status}, {24'h0, s});
   endtask
   task automatic ok(input logic [31:0] v);
      st(ST_OK);
      chk(rep_value, v);
   endtask
   task automatic cap(input logic [7:0] t, m);
      send(CMD_POS_CAPTURE, t, m, 32'h0, 1'b1, 8'h00);
      ok(32'h0);
   endtask
   task automatic rd(input logic [7:0] t, m, input logic [31:0] v);
      send(CMD_COORD_READ, t, m, 32'h0, 1'b1, 8'h00);
      ok(v);
   endtask
   task automatic prg(input logic [7:0] t, m);
      send(CMD_COORD_READ, t, m, 32'hA5A5_A5A5, 1'b0, 8'h00);
   endtask
   task automatic xc(input logic [7:0] t);
      send(CMD_XCALC, t, 8'h00, 32'h0, 1'b1, 8'h00);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_capture;
      @(posedge ref_clk);
      act_pos[64 +: 32] <= 32'h8000_0001;
      act_pos[160 +: 32] <= 32'h7FFF_FFFF;
      cap(8'h03, 8'h02);
      cap(8'h14, 8'h05);
      prg(8'h03, 8'h02);
      chk(accu_out, 32'h8000_0001);
      rd(8'h14, 8'h05, 32'h7FFF_FFFF);
      chk(accu_out, 32'h8000_0001);
   endtask
   task automatic t_xcalc;
      logic [31:0] e [0:7];
      e = '{32'h6B, 32'h5D, 32'h2BC, 32'hE, 32'h2, 32'h4, 32'h67, 32'h63};
      @(posedge ref_clk);
      act_pos[0 +: 32] <= 32'h7;
      cap(8'h01, 8'h00);
      @(posedge ref_clk);
      act_pos[0 +: 32] <= 32'h64;
      cap(8'h02, 8'h00);
      prg(8'h01, 8'h00);
      xc({4'h0, XOP_LOAD});
      chk(xreg_out, 32'h7);
      for (int op = 0; op < 8; op++) begin
         prg(8'h02, 8'h00);
         xc(8'(op));
         ok(32'h0);
         chk(accu_out, e[op]);
      end
      xc({4'h0, XOP_NOT});
      chk(xreg_out, 32'hFFFF_FFF8);
      xc({4'h0, XOP_SWAP});
      chk(accu_out, 32'hFFFF_FFF8);
      chk(xreg_out, 32'h63);
      xc(8'h0B);
      st(ST_BAD_VALUE);
   endtask
   task automatic t_store;
      send(CMD_ACCU_TO_COORD, 8'h07, 8'h04, 32'h0, 1'b1, 8'h00);
      ok(32'h0);
      rd(8'h07, 8'h04, 32'hFFFF_FFF8);
   endtask
   task automatic t_reject;
      @(posedge ref_clk);
      act_pos[64 +: 32] <= 32'h1234;
      send(CMD_POS_CAPTURE, 8'h03, 8'h02, 32'h0, 1'b1, 8'h01);
      st(ST_BAD_CSUM);
      rd(8'h03, 8'h02, 32'h8000_0001);
      send(8'h1E, 8'h03, 8'h02, 32'h0, 1'b1, 8'h00);
      st(ST_BAD_CMD);
      send(CMD_POS_CAPTURE, 8'h01, 8'h06, 32'h0, 1'b1, 8'h00);
      st(ST_BAD_VALUE);
   endtask
   task automatic t_nv;
      int w, r;
      w = wr_count;
      r = rd_count;
      @(posedge ref_clk);
      nv_keep <= 1'b1;
      act_pos[32 +: 32] <= 32'h0BAD_F00D;
      cap(8'h04, 8'h01);
      chk(32'(wr_count), 32'(w + 1));
      chk(csx_nv_model_inst.mem[1][4], 32'h0BAD_F00D);
      cap(8'h00, 8'h01);
      chk(32'(wr_count), 32'(w + 1));
      rd(8'h05, MOTOR_NV_SEL, 32'h0);
      chk(32'(rd_count), 32'(r + 6));
      rd(8'h05, 8'h03, 32'hC0DE_0305);
      rd(8'h00, MOTOR_NV_SEL, 32'h0);
      chk(32'(rd_count), 32'(r + 126));
      chk(32'(zero_hits), 32'h0);
      rd(8'h14, 8'h05, 32'hC0DE_0514);
      @(posedge ref_clk);
      nv_keep <= 1'b0;
      cap(8'h06, 8'h01);
      chk(32'(wr_count), 32'(w + 1));
   endtask
   task automatic t_boot;
      @(posedge ref_clk);
      nv_keep <= 1'b1;
      reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      wait_ready;
      chk(32'(rd_count), 32'h0000_0078);
      chk(32'(zero_hits), 32'h0);
      @(posedge ref_clk);
      nv_keep <= 1'b0;
      rd(8'h04, 8'h01, 32'h0BAD_F00D);
      rd(8'h14, 8'h00, 32'hC0DE_0014);
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_capture;
      t_xcalc;
      t_store;
      t_reject;
      t_nv;
      t_boot;
      final_report;
   end
endmodule
`default_nettype wire
